// file: common/tdmcap_pkg.sv
package tdmcap_pkg;
	// field framing
	localparam int         FIELD_BITS       = 32;
	localparam logic [4:0] FIELD_LAST       = 5'h1F;
	localparam logic [1:0] SHORT_PULSE_CLKS = 2'h2;
	localparam logic [1:0] HIGH_CNT_MAX     = 2'h3;
	localparam logic [1:0] ENTRY_FRAMES     = 2'h2;
	// command field layout
	localparam int ID_ASSIGN_BIT = 31;
	localparam int EXT_CMD_BIT   = 30;
	localparam int CHAIN_SEL_BIT = 29;
	localparam int DEVID_HI      = 28;
	localparam int DEVID_LO      = 24;
	localparam int RW_BIT        = 23;
	localparam int REGID_HI      = 22;
	localparam int REGID_LO      = 16;
	localparam int DATA_HI       = 15;
	localparam int DATA_LO       = 8;
	// audio field layout
	localparam int AUDIO_HI   = 31;
	localparam int AUDIO_LO   = 8;
	localparam int AUDIO_BITS = 24;
	// bit counts within a field at which readback steps happen
	localparam logic [4:0] RD_ARM_CNT    = 5'h08;
	localparam logic [4:0] RD_REG_CNT    = 5'h0F;
	localparam logic [4:0] RD_OE_FIRST   = 5'h0F;
	localparam logic [4:0] RD_DATA_FIRST = 5'h10;
	localparam logic [4:0] RD_DATA_LAST  = 5'h17;
	// device identifiers
	localparam logic [4:0] BROADCAST_ID = 5'h1F;
	localparam logic [4:0] NO_ID        = 5'h00;
	localparam logic [4:0] TOP_ID       = 5'h01;
	localparam logic [4:0] MAX_ID       = 5'h1E;
	// registers
	localparam logic [6:0] REG_CHAN_CTRL    = 7'h13;
	localparam logic [7:0] CHAN_CTRL_RESET  = 8'h00;
	localparam int         CHAN_DISABLE_BIT = 4;
	localparam logic [7:0] UNMAPPED_READ    = 8'h00;

	typedef enum logic [1:0] {FLD_IDLE, FLD_CMD, FLD_EXT, FLD_AUDIO} tdmcap_field_t;
	typedef enum logic [1:0] {OWN_NONE, OWN_LEFT, OWN_RIGHT} tdmcap_own_t;

	typedef struct packed {
		logic       modeActive;
		logic       idValid;
		logic [4:0] devId;
		logic [7:0] chanCtrl;
	} tdmcap_status_t;

	typedef struct packed {
		logic [23:0] left;
		logic [23:0] right;
	} tdmcap_audio_t;
endpackage

// file: src/tdmcap_rst_sync.sv
`timescale 1ns/10ps
`default_nettype none
module tdmcap_rst_sync (
	// clock of the target domain
	input  wire logic clk,
	// reset from the other domain
	input  wire logic rawRst_n,
	// reset for the target domain
	output logic      rst_n
);
	logic stage1_r;
	logic stage2_r;
	logic stage3_r;
	logic rst_n_r;
	logic rst_n_nxt;

	// output moves only once the second and third stages agree
	always_comb begin
		rst_n_nxt = (stage2_r == stage3_r) ? stage3_r : rst_n_r;
	end

	always_ff @(posedge clk) begin
		stage1_r <= rawRst_n;
		stage2_r <= stage1_r;
		stage3_r <= stage2_r;
		rst_n_r  <= rst_n_nxt;
	end

	assign rst_n = rst_n_r;
endmodule
`default_nettype wire

// file: src/tdmcap_cdc_word.sv
`timescale 1ns/10ps
`default_nettype none
module tdmcap_cdc_word #(
	parameter int W = 8
) (
	// source domain
	input  wire logic         srcClk,
	input  wire logic         srcRst_n,
	input  wire logic         srcLoad,
	input  wire logic [W-1:0] srcData,
	// destination domain
	input  wire logic         dstClk,
	input  wire logic         dstRst_n,
	output logic      [W-1:0] dstData,
	output logic              dstPulse
);
	logic [W-1:0] hold_r;
	logic [W-1:0] hold_nxt;
	logic         tgl_r;
	logic         tgl_nxt;
	logic         sync1_r;
	logic         sync2_r;
	logic         sync3_r;
	logic [W-1:0] data_r;
	logic [W-1:0] data_nxt;
	logic         pulse_r;
	logic         pulse_nxt;

	// word is held stable far longer than the toggle takes to cross
	always_comb begin
		hold_nxt = srcLoad ? srcData : hold_r;
		tgl_nxt  = tgl_r ^ srcLoad;
	end

	always_ff @(posedge srcClk) begin
		if (!srcRst_n) begin
			hold_r <= '0;
			tgl_r  <= 1'b0;
		end else begin
			hold_r <= hold_nxt;
			tgl_r  <= tgl_nxt;
		end
	end

	always_comb begin
		pulse_nxt = sync2_r ^ sync3_r;
		data_nxt  = pulse_nxt ? hold_r : data_r;
	end

	always_ff @(posedge dstClk) begin
		if (!dstRst_n) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			sync3_r <= 1'b0;
			data_r  <= '0;
			pulse_r <= 1'b0;
		end else begin
			sync1_r <= tgl_r;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
			data_r  <= data_nxt;
			pulse_r <= pulse_nxt;
		end
	end

	assign dstData  = data_r;
	assign dstPulse = pulse_r;
endmodule
`default_nettype wire

// file: src/tdmcap_port.sv
// How it works
// - a frame strobe high for exactly two bit clocks marks the multiplexed format
// - the mode is entered after two consecutive short-strobe frames
// - commands act only from the frame after mode entry
// - readback pin is driven only from one cycle before the sent data to its last bit
// - at most 30 device ids exist
// - chain input tied high gives device id 1
// - other devices count bit clocks while watching chain input to get their id
// - fields are 32 bits, msb first, low byte meaningless
// - extended commands follow only on the extended flag, then no audio
// - command and extended command fields are both decoded
// - two audio slots are taken only while channel disable is low
// - id-assign flag set makes the frame an id frame only
// - command layout: assign, extended, chain select, id, rw, register, data
// - chain select low addresses this input-chain device
// - id all ones is a broadcast write, id zero selects nothing
// - rw high reads the register back during the data phase
// - input sampled on rising edge, output on falling, enable one cycle early
// - chain output goes high during this device's last audio channel
`timescale 1ns/10ps
`default_nettype none
module tdmcap_port (
	// system side
	input  wire logic                      clk_sys,
	input  wire logic                      reset_n,
	// link pins
	input  wire logic                      serialBitClock,
	input  wire logic                      frameStrobe,
	input  wire logic                      serialIn,
	input  wire logic                      chainIn,
	output logic                           readbackOut,
	output logic                           readbackEn_n,
	output logic                           chainOut,
	// received audio and link state
	output tdmcap_pkg::tdmcap_audio_t      audioSample,
	output logic                           audioValid,
	output tdmcap_pkg::tdmcap_status_t     linkStatus,
	output logic                           statusValid
);
	logic                      linkRst_n;
	logic [31:0]               shift_r;
	logic [31:0]               shift_nxt;
	logic [31:0]               shiftNext;
	logic                      prevStrobe_r;
	logic [1:0]                hiCnt_r;
	logic [1:0]                hiCnt_nxt;
	logic [1:0]                shortCnt_r;
	logic [1:0]                shortCnt_nxt;
	logic                      acceptFrame_r;
	logic                      acceptFrame_nxt;
	logic [4:0]                bitCnt_r;
	logic [4:0]                bitCnt_nxt;
	tdmcap_pkg::tdmcap_field_t field_r;
	tdmcap_pkg::tdmcap_field_t field_nxt;
	tdmcap_pkg::tdmcap_own_t   curOwn_r;
	tdmcap_pkg::tdmcap_own_t   curOwn_nxt;
	logic                      chainSeen_r;
	logic                      chainSeen_nxt;
	logic                      done_r;
	logic                      done_nxt;
	logic [7:0]                ctrl_r;
	logic [7:0]                ctrl_nxt;
	logic                      idFrame_r;
	logic                      idFrame_nxt;
	logic                      idFound_r;
	logic                      idFound_nxt;
	logic [4:0]                idCnt_r;
	logic [4:0]                idCnt_nxt;
	logic                      idValid_r;
	logic                      idValid_nxt;
	logic [4:0]                devId_r;
	logic [4:0]                devId_nxt;
	logic                      rdArm_r;
	logic                      rdArm_nxt;
	logic [7:0]                rdData_r;
	logic [7:0]                rdData_nxt;
	logic [23:0]               left_r;
	logic [23:0]               left_nxt;
	logic                      frameStart;
	logic                      strobeFall;
	logic                      fieldEnd;
	logic                      modeActive;
	logic                      chanDisable;
	logic                      decodeOn;
	logic                      idReq;
	logic                      cmdHit;
	logic                      ctrlWrite;
	logic                      audioLoad;
	tdmcap_pkg::tdmcap_audio_t audioWord;
	tdmcap_pkg::tdmcap_status_t statusWord;
	logic                      readbackOut_r;
	logic                      readbackOut_nxt;
	logic                      readbackEn_n_r;
	logic                      readbackEn_n_nxt;
	logic                      chainOut_r;
	logic                      chainOut_nxt;

	// true when a header (bits 31..23 of a field) addresses this device
	function automatic logic addressed(input logic [8:0] hdr, input logic isCmd,
			input logic valid, input logic [4:0] own);
		logic idHit;
		logic bcast;
		idHit = valid && (hdr[5:1] == own) && (own != tdmcap_pkg::NO_ID);
		bcast = (hdr[5:1] == tdmcap_pkg::BROADCAST_ID) && !hdr[0];
		return !(isCmd && hdr[8]) && !hdr[6] && (idHit || bcast);
	endfunction

	tdmcap_rst_sync u_link_rst (
		.clk      (serialBitClock),
		.rawRst_n (reset_n),
		.rst_n    (linkRst_n)
	);

	// decode of the bit stream, all sampled on the rising edge
	always_comb begin
		shiftNext   = {shift_r[30:0], serialIn};
		frameStart  = frameStrobe && !prevStrobe_r;
		strobeFall  = !frameStrobe && prevStrobe_r;
		fieldEnd    = (field_r != tdmcap_pkg::FLD_IDLE) && (bitCnt_r == tdmcap_pkg::FIELD_LAST);
		modeActive  = (shortCnt_r == tdmcap_pkg::ENTRY_FRAMES);
		chanDisable = ctrl_r[tdmcap_pkg::CHAN_DISABLE_BIT];
		decodeOn    = acceptFrame_r && ((field_r == tdmcap_pkg::FLD_CMD) ||
			(field_r == tdmcap_pkg::FLD_EXT));
		idReq       = decodeOn && (field_r == tdmcap_pkg::FLD_CMD) &&
			shiftNext[tdmcap_pkg::ID_ASSIGN_BIT];
		cmdHit      = fieldEnd && decodeOn && addressed(shiftNext[31:23],
			field_r == tdmcap_pkg::FLD_CMD, idValid_r, devId_r);
		ctrlWrite   = cmdHit && !shiftNext[tdmcap_pkg::RW_BIT] &&
			(shiftNext[tdmcap_pkg::REGID_HI:tdmcap_pkg::REGID_LO] ==
			tdmcap_pkg::REG_CHAN_CTRL);
		audioLoad   = fieldEnd && acceptFrame_r && (field_r == tdmcap_pkg::FLD_AUDIO) &&
			(curOwn_r == tdmcap_pkg::OWN_RIGHT);
		audioWord   = '{left: left_r,
			right: shiftNext[tdmcap_pkg::AUDIO_HI:tdmcap_pkg::AUDIO_LO]};
		statusWord  = '{modeActive: modeActive, idValid: idValid_r, devId: devId_r,
			chanCtrl: ctrl_r};

		shift_nxt       = shiftNext;
		hiCnt_nxt       = hiCnt_r;
		shortCnt_nxt    = shortCnt_r;
		acceptFrame_nxt = acceptFrame_r;
		bitCnt_nxt      = bitCnt_r;
		field_nxt       = field_r;
		curOwn_nxt      = curOwn_r;
		chainSeen_nxt   = chainSeen_r;
		done_nxt        = done_r;
		ctrl_nxt        = ctrl_r;
		idFrame_nxt     = idFrame_r;
		idFound_nxt     = idFound_r;
		idCnt_nxt       = idCnt_r;
		idValid_nxt     = idValid_r;
		devId_nxt       = devId_r;
		rdArm_nxt       = rdArm_r;
		rdData_nxt      = rdData_r;
		left_nxt        = left_r;

		// strobe width measurement and mode entry
		if (frameStart) begin
			hiCnt_nxt = 2'h1;
		end else if (frameStrobe && (hiCnt_r != tdmcap_pkg::HIGH_CNT_MAX)) begin
			hiCnt_nxt = 2'(hiCnt_r + 2'h1);
		end
		if (strobeFall) begin
			if (hiCnt_r == tdmcap_pkg::SHORT_PULSE_CLKS) begin
				if (modeActive) begin
					acceptFrame_nxt = 1'b1;
				end else begin
					shortCnt_nxt    = 2'(shortCnt_r + 2'h1);
					acceptFrame_nxt = 1'b0;
				end
			end else begin
				shortCnt_nxt    = 2'h0;
				acceptFrame_nxt = 1'b0;
			end
		end

		// field sequencing
		if (frameStart) begin
			field_nxt     = tdmcap_pkg::FLD_CMD;
			bitCnt_nxt    = 5'h01;
			curOwn_nxt    = tdmcap_pkg::OWN_NONE;
			chainSeen_nxt = chainIn;
			done_nxt      = 1'b0;
			idFrame_nxt   = 1'b0;
			rdArm_nxt     = 1'b0;
		end else if (field_r != tdmcap_pkg::FLD_IDLE) begin
			bitCnt_nxt    = 5'(bitCnt_r + 5'h01);
			chainSeen_nxt = chainSeen_r || chainIn;
			if ((bitCnt_r == tdmcap_pkg::RD_ARM_CNT) && decodeOn &&
					addressed(shiftNext[8:0], field_r == tdmcap_pkg::FLD_CMD,
					idValid_r, devId_r) && shiftNext[0]) begin
				rdArm_nxt = 1'b1;
			end
			if ((bitCnt_r == tdmcap_pkg::RD_REG_CNT) && rdArm_r) begin
				rdData_nxt = (shiftNext[6:0] == tdmcap_pkg::REG_CHAN_CTRL) ?
					ctrl_r : tdmcap_pkg::UNMAPPED_READ;
			end
			if (fieldEnd) begin
				chainSeen_nxt = 1'b0;
				rdArm_nxt     = 1'b0;
				case (field_r)
					tdmcap_pkg::FLD_CMD: begin
						if (idReq) begin
							field_nxt = tdmcap_pkg::FLD_IDLE;
						end else if (shiftNext[tdmcap_pkg::EXT_CMD_BIT]) begin
							field_nxt = tdmcap_pkg::FLD_EXT;
						end else begin
							field_nxt = tdmcap_pkg::FLD_AUDIO;
						end
					end
					tdmcap_pkg::FLD_EXT: begin
						field_nxt = shiftNext[tdmcap_pkg::EXT_CMD_BIT] ?
							tdmcap_pkg::FLD_EXT : tdmcap_pkg::FLD_IDLE;
					end
					tdmcap_pkg::FLD_AUDIO: begin
						field_nxt = tdmcap_pkg::FLD_AUDIO;
					end
					default: begin
						field_nxt = tdmcap_pkg::FLD_IDLE;
					end
				endcase
				// slot ownership passes along the chain
				if (curOwn_r == tdmcap_pkg::OWN_LEFT) begin
					curOwn_nxt = tdmcap_pkg::OWN_RIGHT;
					left_nxt   = shiftNext[tdmcap_pkg::AUDIO_HI:tdmcap_pkg::AUDIO_LO];
				end else if ((curOwn_r == tdmcap_pkg::OWN_NONE) && (chainSeen_r || chainIn) &&
						!chanDisable && !done_r && (field_nxt == tdmcap_pkg::FLD_AUDIO)) begin
					curOwn_nxt = tdmcap_pkg::OWN_LEFT;
				end else begin
					curOwn_nxt = tdmcap_pkg::OWN_NONE;
				end
				if (curOwn_r == tdmcap_pkg::OWN_RIGHT) begin
					done_nxt = 1'b1;
				end
				if (ctrlWrite) begin
					ctrl_nxt = shiftNext[tdmcap_pkg::DATA_HI:tdmcap_pkg::DATA_LO];
				end
				if (idReq) begin
					idFrame_nxt = 1'b1;
					idFound_nxt = 1'b0;
					idCnt_nxt   = 5'h00;
					idValid_nxt = 1'b0;
				end
			end
		end

		// id assignment: id is one more than the bit clocks counted before chain input rose
		if (idFrame_r && !frameStart) begin
			if (idCnt_r != tdmcap_pkg::BROADCAST_ID) begin
				idCnt_nxt = 5'(idCnt_r + 5'h01);
			end
			if (chainIn && !idFound_r) begin
				idFound_nxt = 1'b1;
				if (idCnt_r < tdmcap_pkg::MAX_ID) begin
					devId_nxt   = 5'(idCnt_r + tdmcap_pkg::TOP_ID);
					idValid_nxt = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge serialBitClock) begin
		if (!linkRst_n) begin
			shift_r       <= '0;
			prevStrobe_r  <= 1'b0;
			hiCnt_r       <= 2'h0;
			shortCnt_r    <= 2'h0;
			acceptFrame_r <= 1'b0;
			bitCnt_r      <= 5'h00;
			field_r       <= tdmcap_pkg::FLD_IDLE;
			curOwn_r      <= tdmcap_pkg::OWN_NONE;
			chainSeen_r   <= 1'b0;
			done_r        <= 1'b0;
			ctrl_r        <= tdmcap_pkg::CHAN_CTRL_RESET;
			idFrame_r     <= 1'b0;
			idFound_r     <= 1'b0;
			idCnt_r       <= 5'h00;
			idValid_r     <= 1'b0;
			devId_r       <= tdmcap_pkg::NO_ID;
			rdArm_r       <= 1'b0;
			rdData_r      <= 8'h00;
			left_r        <= 24'h000000;
		end else begin
			shift_r       <= shift_nxt;
			prevStrobe_r  <= frameStrobe;
			hiCnt_r       <= hiCnt_nxt;
			shortCnt_r    <= shortCnt_nxt;
			acceptFrame_r <= acceptFrame_nxt;
			bitCnt_r      <= bitCnt_nxt;
			field_r       <= field_nxt;
			curOwn_r      <= curOwn_nxt;
			chainSeen_r   <= chainSeen_nxt;
			done_r        <= done_nxt;
			ctrl_r        <= ctrl_nxt;
			idFrame_r     <= idFrame_nxt;
			idFound_r     <= idFound_nxt;
			idCnt_r       <= idCnt_nxt;
			idValid_r     <= idValid_nxt;
			devId_r       <= devId_nxt;
			rdArm_r       <= rdArm_nxt;
			rdData_r      <= rdData_nxt;
			left_r        <= left_nxt;
		end
	end

	// pin outputs change on the falling edge; bitCnt_r names the bit taken next
	always_comb begin
		readbackEn_n_nxt = !(rdArm_r && (bitCnt_r >= tdmcap_pkg::RD_OE_FIRST) &&
			(bitCnt_r <= tdmcap_pkg::RD_DATA_LAST));
		readbackOut_nxt  = 1'b0;
		if (rdArm_r && (bitCnt_r >= tdmcap_pkg::RD_DATA_FIRST) &&
				(bitCnt_r <= tdmcap_pkg::RD_DATA_LAST)) begin
			readbackOut_nxt = rdData_r[3'(tdmcap_pkg::RD_DATA_LAST - bitCnt_r)];
		end
		if (!modeActive) begin
			chainOut_nxt = 1'b0;
		end else if (idFrame_r) begin
			chainOut_nxt = idFound_r;
		end else if (chanDisable) begin
			chainOut_nxt = chainIn && (field_r == tdmcap_pkg::FLD_AUDIO);
		end else begin
			chainOut_nxt = (curOwn_r == tdmcap_pkg::OWN_RIGHT);
		end
	end

	always_ff @(negedge serialBitClock) begin
		if (!linkRst_n) begin
			readbackOut_r  <= 1'b0;
			readbackEn_n_r <= 1'b1;
			chainOut_r     <= 1'b0;
		end else begin
			readbackOut_r  <= readbackOut_nxt;
			readbackEn_n_r <= readbackEn_n_nxt;
			chainOut_r     <= chainOut_nxt;
		end
	end

	assign readbackOut  = readbackOut_r;
	assign readbackEn_n = readbackEn_n_r;
	assign chainOut     = chainOut_r;

	tdmcap_cdc_word #(.W(48)) u_audio_cdc (
		.srcClk   (serialBitClock),
		.srcRst_n (linkRst_n),
		.srcLoad  (audioLoad),
		.srcData  (audioWord),
		.dstClk   (clk_sys),
		.dstRst_n (reset_n),
		.dstData  (audioSample),
		.dstPulse (audioValid)
	);

	tdmcap_cdc_word #(.W(15)) u_status_cdc (
		.srcClk   (serialBitClock),
		.srcRst_n (linkRst_n),
		.srcLoad  (frameStart),
		.srcData  (statusWord),
		.dstClk   (clk_sys),
		.dstRst_n (reset_n),
		.dstData  (linkStatus),
		.dstPulse (statusValid)
	);

	default clocking cb @(posedge serialBitClock);
	endclocking
	default disable iff (!linkRst_n);

	property p_entry_pulse;
		$rose(modeActive) |-> !$past(frameStrobe) && $past(frameStrobe, 2) &&
			$past(frameStrobe, 3) && !$past(frameStrobe, 4);
	endproperty
	a_entry_pulse: assert property (p_entry_pulse) else $error("entry without 2-clock strobe");

	property p_entry_count;
		$rose(modeActive) |-> $past(shortCnt_r) == 2'h1;
	endproperty
	a_entry_count: assert property (p_entry_count) else $error("entry before two frames");

	property p_accept_after_entry;
		$rose(acceptFrame_r) |-> $past(modeActive);
	endproperty
	a_accept_after_entry: assert property (p_accept_after_entry) else $error("early accept");

	property p_readback_window;
		!readbackEn_n_r |-> rdArm_r && (bitCnt_r >= 5'h0F) && (bitCnt_r <= 5'h17);
	endproperty
	a_readback_window: assert property (p_readback_window) else $error("readback out of window");

	property p_id_range;
		idValid_r |-> (devId_r >= 5'h01) && (devId_r <= 5'h1E);
	endproperty
	a_id_range: assert property (p_id_range) else $error("device id out of range");

	property p_id_source;
		$rose(idValid_r) |-> $past(idFrame_r) && $past(chainIn) &&
			(devId_r == 5'($past(idCnt_r) + 5'h01));
	endproperty
	a_id_source: assert property (p_id_source) else $error("id not from chain count");

	property p_id_frame_quiet;
		idFrame_r |-> $stable(ctrl_r);
	endproperty
	a_id_frame_quiet: assert property (p_id_frame_quiet) else $error("write in id frame");

	property p_write_cause;
		$changed(ctrl_r) |-> $past(ctrlWrite) && $past(acceptFrame_r);
	endproperty
	a_write_cause: assert property (p_write_cause) else $error("register changed without write");

	property p_chain_last;
		$rose(curOwn_r == tdmcap_pkg::OWN_RIGHT) && modeActive && !chanDisable |=> chainOut_r;
	endproperty
	a_chain_last: assert property (p_chain_last) else $error("chain out low in last slot");

	c_mode_entry: cover property ($rose(modeActive));
	c_write: cover property (ctrlWrite);
	c_read: cover property ($fell(readbackEn_n_r));
	c_id_assign: cover property ($rose(idValid_r));
endmodule
`default_nettype wire

// file: test/tdmcap_host.sv
`timescale 1ns/10ps
`default_nettype none
module tdmcap_host (
	// link pins toward the device
	output logic     serialBitClock,
	output logic     frameStrobe,
	output logic     serialIn,
	output logic     chainIn,
	// pins from the device
	input wire logic readbackOut,
	input wire logic readbackEn_n,
	input wire logic chainOut
);
	logic [8:0]  rdBits;
	logic [95:0] coBits;
	int          enCnt;
	initial begin
		serialBitClock = 1'b0;
		frameStrobe = 1'b0;
		serialIn = 1'b0;
		chainIn = 1'b1; // top of chain, audio-less devices sit further down
	end
	// one bit time: drive after the falling edge, look at device pins on the rising edge
	task automatic bitc(input logic s, input logic d, input logic c, input int i);
		frameStrobe <= s;
		serialIn <= d;
		chainIn <= c;
		#62.5 serialBitClock = 1'b1;
		if (readbackEn_n === 1'b0) begin
			rdBits = {rdBits[7:0], readbackOut};
			enCnt++;
		end
		if (i >= 0) begin
			coBits[i] = chainOut;
		end
		#62.5 serialBitClock = 1'b0;
	endtask
	// command then two audio slots, no extended fields; hi is the strobe width in bits
	task automatic frame(input logic [31:0] cmd, l, r, input int hi, ch);
		logic [95:0] f;
		f = {cmd, l, r};
		enCnt = 0;
		rdBits = '0;
		for (int i = 0; i < 96; i++) begin
			bitc(i < hi, f[95 - i], i >= ch, i);
		end
	endtask
	task automatic idle(input int n);
		for (int i = 0; i < n; i++) begin
			bitc(1'b0, ~serialIn, chainIn, -1);
		end
	endtask
endmodule
`default_nettype wire

// file: test/tdmcap_port_bench.sv
`timescale 1ns/10ps
`default_nettype none
module tdmcap_port_bench;
	logic                       clk_sys = 1'b0;
	logic                       reset_n;
	logic                       av;
	logic                       statSeen;
	int                         num_errors;
	int                         n_checks;
	int                         cyc;
	wire logic                  serialBitClock;
	wire logic                  frameStrobe;
	wire logic                  serialIn;
	wire logic                  chainIn;
	wire logic                  readbackOut;
	wire logic                  readbackEn_n;
	wire logic                  chainOut;
	wire logic                  audioValid;
	wire logic                  statusValid;
	tdmcap_pkg::tdmcap_audio_t  audioSample;
	tdmcap_pkg::tdmcap_status_t linkStatus;

	tdmcap_port tdmcap_port_i (.clk_sys(clk_sys), .reset_n(reset_n),
		.serialBitClock(serialBitClock), .frameStrobe(frameStrobe), .serialIn(serialIn),
		.chainIn(chainIn), .readbackOut(readbackOut), .readbackEn_n(readbackEn_n),
		.chainOut(chainOut), .audioSample(audioSample), .audioValid(audioValid),
		.linkStatus(linkStatus), .statusValid(statusValid));
	tdmcap_host tdmcap_host_i (.serialBitClock(serialBitClock), .frameStrobe(frameStrobe),
		.serialIn(serialIn), .chainIn(chainIn), .readbackOut(readbackOut),
		.readbackEn_n(readbackEn_n), .chainOut(chainOut));

	always #2.5 clk_sys = ~clk_sys;

	always @(posedge clk_sys) begin
		cyc++;
		if (audioValid === 1'b1) begin
			av = 1'b1;
		end
		if (statusValid === 1'b1) begin
			statSeen = 1'b1;
		end
		if (cyc == 80000) begin
			num_errors++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("errors %0d checks %0d", num_errors, n_checks);
		if (num_errors == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [47:0] got, exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	function automatic logic [31:0] mk(input logic cs, input logic [4:0] id, input logic rw,
			input logic [6:0] rg, input logic [7:0] d);
		return {2'b00, cs, id, rw, rg, d, 8'h00};
	endfunction
	task automatic fr(input logic [31:0] c, input logic [31:0] l = '0, input logic [31:0] r = '0);
		tdmcap_host_i.frame(c, l, r, 2, 0);
	endtask
	// a neutral frame, then the status snapshot taken at its start
	task automatic stat(input logic [14:0] e);
		statSeen = 1'b0;
		fr(32'h0);
		repeat (10) @(posedge clk_sys);
		chk(48'(linkStatus), 48'(e));
		chk(48'(statSeen), 48'h1);
	endtask
	task automatic rd(input logic [31:0] c, input int n, input logic [7:0] e);
		fr(c);
		chk(48'(tdmcap_host_i.enCnt), 48'(n));
		chk(48'(tdmcap_host_i.rdBits[7:0]), 48'(e));
	endtask
	task automatic t_entry();
		fr(32'h0);
		tdmcap_host_i.frame(32'h0, 32'h0, 32'h0, 48, 0);
		fr(mk(1'b0, 5'h1F, 1'b0, 7'h13, 8'h2B));
		stat(15'h0000);
		stat({2'b10, 5'h00, 8'h00});
	endtask
	task automatic t_ident();
		fr(32'h9F13_2B00);
		stat({2'b11, 5'h01, 8'h00});
	endtask
	task automatic t_write();
		fr(mk(1'b0, 5'h01, 1'b0, 7'h13, 8'h2B));
		stat({2'b11, 5'h01, 8'h2B});
		fr(mk(1'b1, 5'h01, 1'b0, 7'h13, 8'h00));
		fr(mk(1'b0, 5'h02, 1'b0, 7'h13, 8'h00));
		fr(mk(1'b0, 5'h00, 1'b0, 7'h13, 8'h00));
		fr(mk(1'b0, 5'h01, 1'b0, 7'h12, 8'h00));
		fr(mk(1'b0, 5'h01, 1'b1, 7'h13, 8'h00));
		stat({2'b11, 5'h01, 8'h2B});
		fr(mk(1'b0, 5'h1F, 1'b0, 7'h13, 8'h0C));
		stat({2'b11, 5'h01, 8'h0C});
	endtask
	task automatic t_read();
		rd(mk(1'b0, 5'h01, 1'b1, 7'h13, 8'h00), 9, 8'h0C);
		rd(mk(1'b0, 5'h1F, 1'b1, 7'h13, 8'h00), 0, 8'h00);
		rd(mk(1'b0, 5'h01, 1'b1, 7'h12, 8'h00), 9, 8'h00);
	endtask
	task automatic t_audio();
		av = 1'b0;
		fr(32'h0, {24'h123456, 8'h00}, {24'hABCDEF, 8'h00});
		repeat (10) @(posedge clk_sys);
		chk(48'(audioSample), 48'h123456ABCDEF);
		chk(48'(av), 48'h1);
		chk(48'({tdmcap_host_i.coBits[48], tdmcap_host_i.coBits[80]}), 48'h1);
		fr(mk(1'b0, 5'h01, 1'b0, 7'h13, 8'h10));
		repeat (10) @(posedge clk_sys);
		av = 1'b0;
		fr(32'h0, {24'h111111, 8'h00}, {24'h222222, 8'h00});
		repeat (10) @(posedge clk_sys);
		chk(48'(av), 48'h0);
		chk(48'(tdmcap_host_i.coBits[48]), 48'h1);
	endtask
	task automatic t_chain();
		tdmcap_host_i.frame(32'h8000_0000, 32'h0, 32'h0, 2, 34);
		chk(48'({tdmcap_host_i.coBits[34], tdmcap_host_i.coBits[35]}), 48'h1);
		stat({2'b11, 5'h03, 8'h10});
	endtask

	initial begin
		reset_n = 1'b0;
		av = 1'b0;
		statSeen = 1'b0;
		num_errors = 0;
		n_checks = 0;
		cyc = 0;
		fork
			tdmcap_host_i.idle(6);
			repeat (16) @(posedge clk_sys);
		join
		@(posedge clk_sys) reset_n <= 1'b1;
		tdmcap_host_i.idle(6);
		chk(48'({readbackEn_n, chainOut, linkStatus}), 48'h10000);
		t_entry();
		t_ident();
		t_write();
		t_read();
		t_audio();
		t_chain();
		print_verdict();
	end
endmodule
`default_nettype wire
